/* File: hw/serious_fault_response_ctrl.v */
// phase removal and serious-fault response control
//
// How it works
// - phase 4 drives while removal bit 3 is 0; bit 3 set removes it.
// - bit 7 of phase removal gates internal rail OV/UV detection; 0 enables.
// - rail OV/UV still stops switching but is never visible in a register.
// - fault response register is one byte, all bits RW, protectable, resets 00h.
// - response bits map to the seven listed fault kinds; bit 3 reserved.
// - faults are recognised from bus voltage monitors and sustained overcurrent.
// - an enabled serious fault halts all phase drives and asserts fail low.
// - a fault is confirmed over a few switching cycles before response.
// - bit 0 at 0: buck high-side short asserts fail, stops, stays latched.
// - restart after latch-off only by toggling chip or switching enable.
// - bit 0 at 1: fail stays released; stop follows related fault settings.
// - bits 1, 2, 4 to 7 make the same choice for their own fault.
`timescale 1ns/1ps
`default_nettype none
`include "serious_fault_defs.vh"

module serious_fault_response_ctrl (
	// clock and reset
	input  wire       clock,
	input  wire       srst,
	// register access from the command decoder
	input  wire [7:0] reg_addr,
	input  wire       reg_write,
	input  wire [7:0] reg_wdata,
	input  wire       write_protect,
	output reg  [7:0] reg_rdata,
	// switching cycle strobe from the modulator
	input  wire       switch_tick,
	// monitor inputs, asynchronous
	input  wire       hs_short_seen,
	input  wire       ls_short_seen,
	input  wire       low_voltage_bus_gnd,
	input  wire       high_voltage_bus_gnd,
	input  wire       sustained_overcurrent,
	input  wire       boost_mode,
	input  wire       internal_rail_pair_fault,
	// related fault responses ask for a stop, asynchronous
	input  wire       related_stop_request,
	// enable pins, asynchronous
	input  wire       chip_enable,
	input  wire       switching_enable,
	// outputs
	output reg  [3:0] phase_drive_outputs,
	output reg        system_fail_out_n,
	output reg        fault_latched
);

	// ---------------------------------------------------------------
	// helper functions
	// ---------------------------------------------------------------
	// command code selects the given register
	function reg_hit;
		input [7:0] addr;
		input [7:0] offset;
		begin
			reg_hit = (addr == offset);
		end
	endfunction

	// hint seen in the matching conversion direction
	function in_mode;
		input hint;
		input want_boost;
		input boost_now;
		begin
			in_mode = hint & (boost_now == want_boost);
		end
	endfunction

	// level was high last cycle and is low now
	function fell_now;
		input was;
		input now_level;
		begin
			fell_now = was & !now_level;
		end
	endfunction

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	// bit 0 is spare and stays low
	reg [10:0] sync1_reg;
	reg [10:0] sync2_reg;
	wire [10:0] raw_in;

	assign raw_in = {related_stop_request, internal_rail_pair_fault, boost_mode,
			sustained_overcurrent, high_voltage_bus_gnd, low_voltage_bus_gnd,
			ls_short_seen, hs_short_seen, switching_enable, chip_enable, 1'b0};

	always @(posedge clock) begin
		if (srst) begin
			sync1_reg <= 11'h000;
			sync2_reg <= 11'h000;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
		end
	end

	wire chip_en_s     = sync2_reg[1];
	wire switch_en_s   = sync2_reg[2];
	wire hs_short_s    = sync2_reg[3];
	wire ls_short_s    = sync2_reg[4];
	wire low_gnd_s     = sync2_reg[5];
	wire high_gnd_s    = sync2_reg[6];
	wire overcurrent_s = sync2_reg[7];
	wire boost_s       = sync2_reg[8];
	wire rail_fault_s  = sync2_reg[9];
	wire related_s     = sync2_reg[10];

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	reg [7:0] phase_removal_control_reg;
	reg [7:0] serious_fault_response_control_reg;

	// protect blocks both registers; nothing reports a refused write
	wire wr_ok = reg_write && !write_protect;

	always @(posedge clock) begin
		if (srst) begin
			phase_removal_control_reg          <= `PHASE_REMOVAL_RESET;
			serious_fault_response_control_reg <= `SERIOUS_FAULT_RESET;
		end else if (wr_ok) begin
			if (reg_hit(reg_addr, `PHASE_REMOVAL_OFFSET)) begin
				phase_removal_control_reg <= reg_wdata;
			end
			if (reg_hit(reg_addr, `SERIOUS_FAULT_OFFSET)) begin
				// all eight bits stored, reserved one too
				serious_fault_response_control_reg <= reg_wdata;
			end
		end
	end

	// read data; rail detection results are never mixed in
	always @(posedge clock) begin
		if (srst) begin
			reg_rdata <= `UNMAPPED_READ_VALUE;
		end else begin
			case (reg_addr)
				`PHASE_REMOVAL_OFFSET: begin
					reg_rdata <= phase_removal_control_reg;
				end
				`SERIOUS_FAULT_OFFSET: begin
					reg_rdata <= serious_fault_response_control_reg;
				end
				default: begin
					reg_rdata <= `UNMAPPED_READ_VALUE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// suspect classification from bus monitors and overcurrent
	// ---------------------------------------------------------------
	reg [7:0] suspect;

	always @* begin
		suspect = 8'h00;
		// switch shorts show as sustained overcurrent with a switch hint
		// bit positions follow the response register map
		suspect[`BUCK_HS_SHORT_BIT]      = in_mode(hs_short_s & overcurrent_s, 1'b0, boost_s);
		suspect[`BOOST_HS_SHORT_BIT]     = in_mode(hs_short_s & overcurrent_s, 1'b1, boost_s);
		suspect[`BUCK_LS_SHORT_BIT]      = in_mode(ls_short_s & overcurrent_s, 1'b0, boost_s);
		suspect[`BOOST_LS_SHORT_BIT]     = in_mode(ls_short_s & overcurrent_s, 1'b1, boost_s);
		// bus shorts show on the bus voltage monitors
		suspect[`BUCK_LOW_BUS_GND_BIT]   = in_mode(low_gnd_s, 1'b0, boost_s);
		suspect[`BUCK_HIGH_BUS_GND_BIT]  = in_mode(high_gnd_s, 1'b0, boost_s);
		suspect[`BOOST_HIGH_BUS_GND_BIT] = in_mode(high_gnd_s, 1'b1, boost_s);
		suspect[`RESERVED_FAULT_BIT]     = 1'b0;
	end

	wire [7:0] confirmed;

	fault_confirm u_confirm (
		.clock       (clock),
		.srst        (srst),
		.switch_tick (switch_tick),
		.suspect     (suspect),
		.confirmed   (confirmed)
	);

	// ---------------------------------------------------------------
	// response selection
	// ---------------------------------------------------------------
	// reserved bit never confirms, so its setting is ignored
	// a 0 in the response bit means latch off and assert fail
	wire [7:0] latching   = confirmed & ~serious_fault_response_control_reg
			& `FAULT_KIND_MASK;
	wire [7:0] deferring  = confirmed & serious_fault_response_control_reg
			& `FAULT_KIND_MASK;
	wire latch_event      = |latching;
	// deferred fault stops only if the related fault response asks
	wire deferred_stop    = (|deferring) & related_s;

	// ---------------------------------------------------------------
	// restart by enable toggle
	// ---------------------------------------------------------------
	reg chip_en_d_reg;
	reg switch_en_d_reg;

	always @(posedge clock) begin
		if (srst) begin
			chip_en_d_reg   <= 1'b0;
			switch_en_d_reg <= 1'b0;
		end else begin
			chip_en_d_reg   <= chip_en_s;
			switch_en_d_reg <= switch_en_s;
		end
	end

	// dropping either enable clears the latch; rising again restarts
	// both enables must be high again before switching resumes
	wire chip_en_fell   = fell_now(chip_en_d_reg, chip_en_s);
	wire switch_en_fell = fell_now(switch_en_d_reg, switch_en_s);
	wire enable_drop    = chip_en_fell | switch_en_fell;

	// ---------------------------------------------------------------
	// latch state machine
	// ---------------------------------------------------------------
	// run: converting; latched: off with fail low; rearm: waiting for enables
	localparam [1:0] ST_RUN     = 2'b00;
	localparam [1:0] ST_LATCHED = 2'b01;
	localparam [1:0] ST_REARM   = 2'b10;

	reg [1:0] state_reg;
	reg [1:0] state_next;

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (latch_event) begin
					state_next = ST_LATCHED;
				end
			end
			ST_LATCHED: begin
				// a new latch event in the same cycle keeps the latch
				if (enable_drop && !latch_event) begin
					state_next = ST_REARM;
				end
			end
			ST_REARM: begin
				if (latch_event) begin
					state_next = ST_LATCHED;
				end else if (chip_en_s && switch_en_s) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_LATCHED;
			end
		endcase
	end

	always @(posedge clock) begin
		if (srst) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	wire latched_next = (state_next == ST_LATCHED);

	// ---------------------------------------------------------------
	// rail OV/UV gating
	// ---------------------------------------------------------------
	// acts on switching only; deliberately not readable
	// rail results never reach the status path
	wire rail_stop = rail_fault_s
			& !phase_removal_control_reg[`RAIL_DETECT_OFF_BIT];

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// outputs registered so pins never glitch
	wire run_ok = chip_en_s & switch_en_s & (state_next == ST_RUN)
			& !deferred_stop & !rail_stop;

	always @(posedge clock) begin
		if (srst) begin
			phase_drive_outputs <= 4'h0;
			system_fail_out_n   <= 1'b1;
			fault_latched       <= 1'b0;
		end else begin
			// phases 1 to 3 follow run_ok only; no removal bit gates them
			phase_drive_outputs[2:0] <= {3{run_ok}};
			phase_drive_outputs[3]   <= run_ok
					& !phase_removal_control_reg[`PHASE4_REMOVE_BIT];
			system_fail_out_n   <= !latched_next;
			fault_latched       <= latched_next;
		end
	end

endmodule // serious_fault_response_ctrl
`default_nettype wire

/* File: hw/serious_fault_defs.vh */
// register offsets, field positions, reset values and timing counts
`ifndef SERIOUS_FAULT_DEFS_VH
`define SERIOUS_FAULT_DEFS_VH

// register offsets (command codes)
`define PHASE_REMOVAL_OFFSET    8'hBC
`define SERIOUS_FAULT_OFFSET    8'hBD

// reset values
`define PHASE_REMOVAL_RESET     8'h00
`define SERIOUS_FAULT_RESET     8'h00
`define UNMAPPED_READ_VALUE     8'h00

// phase removal fields
`define PHASE4_REMOVE_BIT       3
`define RAIL_DETECT_OFF_BIT     7

// serious fault response fields
`define BUCK_HS_SHORT_BIT       0
`define BOOST_HS_SHORT_BIT      1
`define BUCK_LOW_BUS_GND_BIT    2
`define RESERVED_FAULT_BIT      3
`define BUCK_LS_SHORT_BIT       4
`define BOOST_LS_SHORT_BIT      5
`define BUCK_HIGH_BUS_GND_BIT   6
`define BOOST_HIGH_BUS_GND_BIT  7

// mask of the bits that carry a fault; the reserved bit has none
`define FAULT_KIND_MASK         8'hF7

// switching cycles a suspect must persist before it is confirmed
`define CONFIRM_SWITCH_CYCLES   3
`define CONFIRM_COUNT_WIDTH     2

`endif

/* File: hw/fault_confirm.v */
// per-fault confirmation over consecutive switching cycles
`timescale 1ns/1ps
`default_nettype none
`include "serious_fault_defs.vh"

module fault_confirm (
	// clock and reset
	input  wire       clock,
	input  wire       srst,
	// switching cycle strobe
	input  wire       switch_tick,
	// synchronised suspect levels, one per fault kind
	input  wire [7:0] suspect,
	// confirmed faults, level
	output wire [7:0] confirmed
);

	// ---------------------------------------------------------------
	// counters
	// ---------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_kind
			reg [`CONFIRM_COUNT_WIDTH-1:0] count_reg;
			reg                            hit_reg;

			always @(posedge clock) begin
				if (srst) begin
					count_reg <= {`CONFIRM_COUNT_WIDTH{1'b0}};
					hit_reg   <= 1'b0;
				end else if (!suspect[i]) begin
					// suspect vanished before confirmation: start over
					count_reg <= {`CONFIRM_COUNT_WIDTH{1'b0}};
					hit_reg   <= 1'b0;
				end else if (switch_tick && !hit_reg) begin
					if (count_reg == `CONFIRM_SWITCH_CYCLES - 1) begin
						hit_reg <= 1'b1;
					end else begin
						count_reg <= count_reg + 1'b1;
					end
				end
			end

			wire [7:0] kind_mask = `FAULT_KIND_MASK;

			assign confirmed[i] = hit_reg & kind_mask[i];
		end
	endgenerate

endmodule // fault_confirm
`default_nettype wire

/* File: bench/serious_fault_response_ctrl_properties.sv */
// port assertions for the fault response control
`timescale 1ns/1ps
`default_nettype none
module sfr_props (
	input wire logic       clock, srst, reg_write, write_protect,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	input wire logic       hs_short_seen, ls_short_seen,
	input wire logic       low_voltage_bus_gnd, high_voltage_bus_gnd,
	input wire logic       chip_enable, switching_enable,
	input wire logic [3:0] phase_drive_outputs,
	input wire logic       system_fail_out_n, fault_latched
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	wire quiet = !(hs_short_seen | ls_short_seen | low_voltage_bus_gnd | high_voltage_bus_gnd);
	wire on = chip_enable & switching_enable;
	sequence bd_wr(p); reg_write && write_protect == p && reg_addr == 8'hBD; endsequence
	sequence bd_rd; !reg_write && reg_addr == 8'hBD; endsequence
	AST_WRITE_READ: assert property (bd_wr(1'b0) ##1 bd_rd |=> reg_rdata == $past(reg_wdata, 2))
		else $error("readback differs from written byte");
	AST_PROTECT: assert property (bd_wr(1'b1) ##1 bd_rd |=> $stable(reg_rdata))
		else $error("protected write changed register");
	AST_UNMAPPED: assert property (reg_addr != 8'hBC && reg_addr != 8'hBD |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_FAIL_STOPS: assert property (!system_fail_out_n |-> fault_latched && phase_drive_outputs == 4'h0)
		else $error("fail low while phases drive");
	AST_FAIL_HOLDS: assert property (on [*4] ##0 !system_fail_out_n |=> !system_fail_out_n)
		else $error("fail released without enable toggle");
	AST_REARM: assert property ((!chip_enable && quiet) [*8] |-> system_fail_out_n && phase_drive_outputs == 4'h0)
		else $error("no rearm after enable drop");
	AST_CONFIRM: assert property ($fell(system_fail_out_n) |-> $past(!quiet, 5))
		else $error("fail without sustained fault");
	AST_RESET_STATE: assert property (disable iff (1'b0) srst |=> phase_drive_outputs == 4'h0 && system_fail_out_n && !fault_latched && reg_rdata == 8'h00)
		else $error("outputs not at reset values");
endmodule // sfr_props
bind serious_fault_response_ctrl sfr_props u_sfr_props (.clock, .srst, .reg_write, .write_protect,
	.reg_addr, .reg_wdata, .reg_rdata, .hs_short_seen, .ls_short_seen, .low_voltage_bus_gnd,
	.high_voltage_bus_gnd, .chip_enable, .switching_enable, .phase_drive_outputs,
	.system_fail_out_n, .fault_latched);
`default_nettype wire

/* File: bench/shutdown_partner.sv */
// far side: shutdown circuit and restart through chip enable
`timescale 1ns/1ps
`default_nettype none
module shutdown_partner (
	input wire logic clock, srst, system_fail_out_n, restart,
	output var logic chip_enable, shutdown_seen
);
	logic [3:0] off_count;
	always @(posedge clock) begin
		if (srst) begin
			chip_enable <= 1'b1;
			shutdown_seen <= 1'b0;
			off_count <= 4'h0;
		end else begin
			if (!system_fail_out_n) shutdown_seen <= 1'b1;
			if (restart) begin
				off_count <= 4'h9;
				shutdown_seen <= 1'b0;
			end else if (off_count != 4'h0) off_count <= off_count - 4'h1;
			chip_enable <= (off_count == 4'h0) && !restart;
		end
	end
endmodule // shutdown_partner
`default_nettype wire

/* File: bench/serious_fault_response_ctrl_tb_top.sv */
// self-checking bench for the fault response control
`timescale 1ns/1ps
`default_nettype none
module serious_fault_response_ctrl_tb_top;
	logic clock = 1'b0, srst = 1'b1, reg_write = 1'b0, write_protect = 1'b0, switch_tick = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic hs = 1'b0, ls = 1'b0, lg = 1'b0, hg = 1'b0, oc = 1'b0, boost = 1'b0;
	logic rail = 1'b0, rstop = 1'b0, sw_en = 1'b1, restart = 1'b0;
	logic chip_enable, shutdown_seen, system_fail_out_n, fault_latched;
	logic [3:0] phase_drive_outputs;
	logic [1:0] tick_div = 2'h0;
	int fails = 0, check_count = 0, k, r;
	// monitor pattern {hs, ls, lg, hg, oc, boost} per response bit
	logic [5:0] mon_tab [8] = '{6'h22, 6'h23, 6'h08, 6'h00, 6'h12, 6'h13, 6'h04, 6'h05};
	serious_fault_response_ctrl u_serious_fault_response_ctrl (.clock, .srst, .reg_addr,
		.reg_write, .reg_wdata, .write_protect, .reg_rdata, .switch_tick, .hs_short_seen(hs),
		.ls_short_seen(ls), .low_voltage_bus_gnd(lg), .high_voltage_bus_gnd(hg),
		.sustained_overcurrent(oc), .boost_mode(boost), .internal_rail_pair_fault(rail),
		.related_stop_request(rstop), .chip_enable, .switching_enable(sw_en),
		.phase_drive_outputs, .system_fail_out_n, .fault_latched);
	shutdown_partner u_shutdown_partner (.clock, .srst, .system_fail_out_n, .restart,
		.chip_enable, .shutdown_seen);
	initial forever #5 clock = ~clock;
	always @(posedge clock) begin
		tick_div <= tick_div + 2'h1;
		switch_tick <= (tick_div == 2'h3);
	end
	task automatic chk(input string what, input logic [7:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize;
		if (fails == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic cph(input logic [7:0] exp);
		chk("phases", {4'h0, phase_drive_outputs}, exp);
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		@(posedge clock);
		reg_addr <= a;
		step(2);
		chk("reg_rdata", reg_rdata, exp);
	endtask
	task automatic wait_fail;
		int n;
		for (n = 0; n < 60 && system_fail_out_n !== 1'b0; n++) begin
			@(posedge clock);
			#1;
		end
		if (n == 60) begin
			fails++;
			summarize();
		end
		#1;
	endtask
	initial begin
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		rd(8'hBC, 8'h00);
		rd(8'hBD, 8'h00);
		cph(8'h0F);
		wr(8'hBD, 8'h08);
		rd(8'hBD, 8'h08);
		wr(8'hBD, 8'hFF);
		rd(8'hBD, 8'hFF);
		write_protect <= 1'b1;
		wr(8'hBD, 8'h00);
		wr(8'hBC, 8'h08);
		rd(8'hBD, 8'hFF);
		rd(8'hBC, 8'h00);
		write_protect <= 1'b0;
		rd(8'hBE, 8'h00);
		wr(8'hBC, 8'h08);
		step(3);
		cph(8'h07);
		wr(8'hBC, 8'h00);
		rail <= 1'b1;
		step(5);
		cph(8'h00);
		chk("fail", {7'h0, system_fail_out_n}, 8'h01);
		rd(8'hBC, 8'h00);
		wr(8'hBC, 8'h80);
		step(3);
		cph(8'h0F);
		rail <= 1'b0;
		wr(8'hBC, 8'h00);
		for (r = 0; r < 2; r++) begin
			wr(8'hBD, r ? 8'hF7 : 8'h08);
			for (k = 0; k < 8; k++) begin
				if (k == 3) continue;
				{hs, ls, lg, hg, oc, boost} <= mon_tab[k];
				step(6);
				chk("early fail", {7'h0, system_fail_out_n}, 8'h01);
				if (r == 0) begin
					wait_fail();
					cph(8'h00);
					chk("latched", {7'h0, fault_latched}, 8'h01);
					{hs, ls, lg, hg, oc, boost} <= 6'h00;
					step(8);
					chk("held", {6'h0, system_fail_out_n, shutdown_seen}, 8'h01);
					if (k % 2) begin
						sw_en <= 1'b0;
						step(6);
						sw_en <= 1'b1;
					end else begin
						restart <= 1'b1;
						@(posedge clock);
						restart <= 1'b0;
					end
					step(24);
				end else begin
					step(20);
					cph(8'h0F);
					rstop <= 1'b1;
					step(4);
					cph(8'h00);
					rstop <= 1'b0;
					{hs, ls, lg, hg, oc, boost} <= 6'h00;
					step(6);
				end
				chk("run", {3'h0, phase_drive_outputs, system_fail_out_n}, 8'h1F);
			end
		end
		summarize();
	end
endmodule // serious_fault_response_ctrl_tb_top
`default_nettype wire
